/* File: hw/cpu_write_buffer_unit.sv */
`include "wbuf_params.svh"

module cpu_write_buffer_unit
    import wbuf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    // Internal write request; io_single marks a plain port output write.
    input  wire logic        wr_valid,
    input  wire wr_req_type  wr_req,
    input  wire logic        wr_io_single,
    output logic             wr_ready,
    // Internal read request.
    input  wire logic        rd_valid,
    input  wire rd_req_type  rd_req,
    output logic             rd_ready,
    // Locked sequence: lk_start asks for the read, lk_wr_* gives the result.
    input  wire logic        lk_start,
    input  wire logic        lk_wr_valid,
    input  wire wr_req_type  lk_wr_req,
    input  wire logic        invalidate,
    // Execution stall while a single port output write is in flight.
    output logic             exec_stall,
    // Cache update for write hits.
    output logic             cache_wr,
    output logic [31:0]      cache_addr,
    // External bus.
    output logic             bus_start,
    output bus_cyc_type      bus_cyc,
    output logic             bus_lock,
    input  wire logic        bus_idle,
    input  wire logic        bus_done
);
    typedef struct packed {
        bus_state_type             state;
        wr_req_type [`WB_ENTRIES-1:0] ent;
        logic [`WB_PTR_W-1:0]      rp;
        logic [`WB_PTR_W-1:0]      wp;
        logic [`WB_CNT_W-1:0]      cnt;
        logic                      reorder_blk;
        logic                      start;
        bus_cyc_type               cyc;
        logic                      lock;
        logic                      stall;
        logic                      cwr;
        logic [`WB_ADDR_W-1:0]     caddr;
        logic                      wrdy;
        logic                      rrdy;
        logic [`WB_FIFO_CW-1:0]    fcnt;
        logic [`WB_FIFO_CW-1:0]    stale;
    } unit_state_type;

    unit_state_type st_r;
    unit_state_type st_nxt;

    // FIFO staging of incoming posted writes.
    wr_req_type f_out;
    logic       f_valid;
    logic       f_pop;
    logic       f_in_ready;
    logic       post_in;

    function automatic bus_cyc_type wr_cyc(input wr_req_type w);
        bus_cyc_type c;
        c.addr  = w.addr;
        c.data  = w.data;
        c.be    = w.be;
        c.io    = w.io;
        c.write = 1'b1;
        return c;
    endfunction

    function automatic logic all_hits(input unit_state_type s);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `WB_ENTRIES; i++) begin
            if (`WB_PTR_W'(i - int'(s.rp)) < s.cnt[`WB_PTR_W-1:0] ||
                s.cnt == `WB_CNT_W'(`WB_ENTRIES)) begin
                ok = ok & s.ent[i].hit;
            end
        end
        return ok;
    endfunction

    assign post_in = wr_valid && st_r.wrdy && !wr_io_single &&
                     st_r.state != ST_LK_RD && st_r.state != ST_LK_WAIT &&
                     st_r.state != ST_LK_WR;

    wbuf_fifo #(
        .WIDTH (`WB_REQ_W),
        .DEPTH (`WB_FIFO_DEPTH)
    ) stage_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (post_in),
        .in_ready  (f_in_ready),
        .in_data   (wr_req),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_out)
    );

    logic bypass;
    logic take_ent;
    logic bus_free;
    logic drained;
    logic rd_ok;
    wr_req_type f_ent;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = 1'b0;
        st_nxt.cwr   = 1'b0;
        st_nxt.rrdy  = 1'b0;
        bus_free     = (st_r.state == ST_IDLE) && bus_idle && !st_r.start;
        drained      = (st_r.cnt == '0) && !f_valid;
        bypass       = f_valid && bus_free && (st_r.cnt == '0);
        take_ent     = f_valid && !bypass &&
                       (st_r.cnt != `WB_CNT_W'(`WB_ENTRIES));
        f_pop        = bypass || take_ent;
        // staged writes lose hit
        // Writes still waiting in the staging FIFO at an invalidation are
        // counted, so those taken into the entries are flagged as misses; cache_wr still follows their own hit.
        f_ent        = f_out;
        if (st_r.stale != '0) begin
            f_ent.hit = 1'b0;
        end
        st_nxt.fcnt  = st_r.fcnt + `WB_FIFO_CW'(post_in) -
                       `WB_FIFO_CW'(f_pop);
        st_nxt.stale = st_r.stale -
                       `WB_FIFO_CW'(f_pop && st_r.stale != '0);
        if (invalidate) begin
            st_nxt.stale = st_nxt.fcnt;
        end
        rd_ok        = rd_valid && !rd_req.hit && !rd_req.locked &&
                       !rd_req.io && !st_r.reorder_blk &&
                       all_hits(st_r) && !f_valid;
        if (f_pop && f_out.hit) begin
            st_nxt.cwr   = 1'b1;
            st_nxt.caddr = f_out.addr;
        end
        if (take_ent) begin
            st_nxt.ent[st_r.wp] = f_ent;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (invalidate) begin
            for (int i = 0; i < `WB_ENTRIES; i++) begin
                st_nxt.ent[i].hit = 1'b0;
            end
        end
        case (st_r.state)
            ST_IDLE: begin
                if (!bus_free) begin
                end else if (bypass) begin
                    st_nxt.start = 1'b1;
                    st_nxt.cyc   = wr_cyc(f_out);
                    st_nxt.state = ST_WR;
                end else if (wr_valid && wr_io_single && drained) begin
                    st_nxt.start = 1'b1;
                    st_nxt.cyc   = wr_cyc(wr_req);
                    st_nxt.stall = 1'b1;
                    st_nxt.state = ST_IO_WR;
                end else if (lk_start && drained) begin
                    st_nxt.start = 1'b1;
                    st_nxt.lock  = 1'b1;
                    st_nxt.cyc   = '{addr: rd_req.addr, data: '0, be: '1,
                                     io: 1'b0, write: 1'b0};
                    st_nxt.state = ST_LK_RD;
                end else if (rd_valid && !lk_start &&
                             (drained || rd_ok)) begin
                    if (!drained) begin
                        st_nxt.reorder_blk = 1'b1;
                        for (int i = 0; i < `WB_ENTRIES; i++) begin
                            st_nxt.ent[i].hit = 1'b0;
                        end
                    end
                    st_nxt.start = 1'b1;
                    st_nxt.cyc   = '{addr: rd_req.addr, data: '0, be: '0,
                                     io: rd_req.io, write: 1'b0};
                    st_nxt.state = ST_RD;
                end else if (st_r.cnt != '0) begin
                    st_nxt.start = 1'b1;
                    st_nxt.cyc   = wr_cyc(st_r.ent[st_r.rp]);
                    st_nxt.rp    = st_r.rp + 1'b1;
                    st_nxt.state = ST_WR;
                end
            end
            ST_WR, ST_RD: begin
                if (bus_done) begin
                    st_nxt.rrdy  = (st_r.state == ST_RD);
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_IO_WR: begin
                if (bus_done) begin
                    st_nxt.stall = 1'b0;
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_LK_RD: begin
                if (bus_done) begin
                    st_nxt.rrdy  = 1'b1;
                    st_nxt.state = ST_LK_WAIT;
                end
            end
            ST_LK_WAIT: begin
                if (lk_wr_valid) begin
                    st_nxt.start = 1'b1;
                    st_nxt.cyc   = wr_cyc(lk_wr_req);
                    st_nxt.cwr   = lk_wr_req.hit;
                    st_nxt.caddr = lk_wr_req.addr;
                    st_nxt.state = ST_LK_WR;
                end
            end
            ST_LK_WR: begin
                if (bus_done) begin
                    st_nxt.lock  = 1'b0;
                    st_nxt.state = ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
        st_nxt.cnt = st_r.cnt + `WB_CNT_W'(take_ent) -
                     `WB_CNT_W'(st_nxt.rp != st_r.rp);
        if (st_nxt.cnt == '0) begin
            st_nxt.reorder_blk = 1'b0;
        end
        // ready only with room
        // Ready is registered, so it counts this cycle's push and pop; a
        // ready that lagged the full flag by a cycle would drop a write.
        st_nxt.wrdy = (st_nxt.fcnt != `WB_FIFO_CW'(`WB_FIFO_DEPTH)) &&
                      st_nxt.state != ST_LK_RD &&
                      st_nxt.state != ST_LK_WAIT &&
                      st_nxt.state != ST_LK_WR;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wr_ready   = st_r.wrdy;
    assign rd_ready   = st_r.rrdy;
    assign exec_stall = st_r.stall;
    assign cache_wr   = st_r.cwr;
    assign cache_addr = st_r.caddr;
    assign bus_start  = st_r.start;
    assign bus_cyc    = st_r.cyc;
    assign bus_lock   = st_r.lock;

    // =========================================================
    // Checks
    // =========================================================
    // entry limit
    AST_CNT_MAX: assert property (@(posedge clk) disable iff (srst)
        st_r.cnt <= `WB_CNT_W'(`WB_ENTRIES))
        else $error("entry count above limit");
    AST_LOCK_DRAINED: assert property (@(posedge clk) disable iff (srst)
        $rose(st_r.lock) |-> st_r.cnt == '0)
        else $error("hold raised with pending entries");
    AST_LOCK_DROP: assert property (@(posedge clk) disable iff (srst)
        st_r.state == ST_LK_WR && bus_done |=> !st_r.lock)
        else $error("hold not released after locked write");
    AST_IO_STALL: assert property (@(posedge clk) disable iff (srst)
        st_r.state == ST_IO_WR |-> st_r.stall)
        else $error("no stall during single port write");
    AST_REORDER_MISS: assert property (@(posedge clk) disable iff (srst)
        $rose(st_r.reorder_blk) |-> !all_hits(st_r) || st_r.cnt == '0)
        else $error("entries still hits after reorder");
    AST_ONE_REORDER: assert property (@(posedge clk) disable iff (srst)
        st_r.reorder_blk && st_r.state == ST_IDLE &&
        st_nxt.state == ST_RD |-> drained)
        else $error("second read reordered");
    sequence lk_rd_done;
        st_r.state == ST_LK_RD && bus_done;
    endsequence
    AST_LOCK_GAP: assert property (@(posedge clk) disable iff (srst)
        lk_rd_done |=> st_r.state == ST_LK_WAIT && st_r.lock)
        else $error("locked sequence broken");
    AST_BYPASS: assert property (@(posedge clk) disable iff (srst)
        bypass |=> bus_start && bus_cyc.write)
        else $error("bypass write not started");
    AST_WRDY_ROOM: assert property (@(posedge clk) disable iff (srst)
        st_r.wrdy |-> f_in_ready)
        else $error("write ready without staging room");
    AST_REP_POSTED: assert property (@(posedge clk) disable iff (srst)
        wr_valid && st_r.wrdy && !wr_io_single |-> post_in)
        else $error("posted port write not taken");
    AST_IO_UNPOSTED: assert property (@(posedge clk) disable iff (srst)
        wr_io_single |-> !post_in)
        else $error("single port write posted");
    AST_IO_RD_WAIT: assert property (@(posedge clk) disable iff (srst)
        st_r.state == ST_IDLE && st_nxt.state == ST_RD && rd_req.io
        |-> drained)
        else $error("port read overtook buffered writes");
    AST_LK_RD_EXT: assert property (@(posedge clk) disable iff (srst)
        $rose(st_r.lock) |-> bus_start && !bus_cyc.write)
        else $error("locked read not sent to bus");
    AST_LK_DRAIN: assert property (@(posedge clk) disable iff (srst)
        st_r.state == ST_IDLE && st_nxt.state == ST_LK_RD
        |-> st_r.cnt == '0 && !f_valid)
        else $error("locked cycle with pending writes");
    sequence lk_wr_go;
        st_r.state == ST_LK_WAIT && lk_wr_valid;
    endsequence
    AST_LK_WR: assert property (@(posedge clk) disable iff (srst)
        lk_wr_go |=> bus_start && bus_cyc.write && bus_lock)
        else $error("locked result write not issued");
    sequence io_wr_done;
        st_r.state == ST_IO_WR && bus_done;
    endsequence
    AST_STALL_DROP: assert property (@(posedge clk) disable iff (srst)
        io_wr_done |=> !exec_stall)
        else $error("stall kept after port write");
    AST_RD_AFTER_IO: assert property (@(posedge clk) disable iff (srst)
        st_r.state == ST_IO_WR && !bus_done |=> !bus_start)
        else $error("cycle started during port write");
    AST_INV_MISS: assert property (@(posedge clk) disable iff (srst)
        invalidate |=> !all_hits(st_r) || st_r.cnt == '0)
        else $error("entries still hits after invalidation");
endmodule

/* File: hw/wbuf_fifo.sv */
`include "wbuf_params.svh"

module wbuf_fifo
    import wbuf_pkg::*;
#(
    parameter int WIDTH = `WB_REQ_W,
    parameter int DEPTH = `WB_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_state_type;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_state_type   st_r;
    fifo_state_type   st_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule

/* File: include/wbuf_params.svh */
`ifndef WBUF_PARAMS_SVH
`define WBUF_PARAMS_SVH

// Number of posted write entries.
`define WB_ENTRIES      4
`define WB_PTR_W        2
`define WB_CNT_W        3
`define WB_ADDR_W       32
`define WB_DATA_W       32
`define WB_BE_W         4
// Depth of the staging FIFO in front of the posted entries.
`define WB_FIFO_DEPTH   16
`define WB_FIFO_AW      4
`define WB_FIFO_CW      5
// Packed width of one write request: addr + data + be + io + hit.
`define WB_REQ_W        70

`endif

/* File: include/wbuf_pkg.sv */
package wbuf_pkg;
`include "wbuf_params.svh"

    typedef struct packed {
        logic [`WB_ADDR_W-1:0] addr;
        logic [`WB_DATA_W-1:0] data;
        logic [`WB_BE_W-1:0]   be;
        logic                  io;
        logic                  hit;
    } wr_req_type;

    typedef struct packed {
        logic [`WB_ADDR_W-1:0] addr;
        logic                  io;
        logic                  hit;
        logic                  locked;
    } rd_req_type;

    typedef struct packed {
        logic [`WB_ADDR_W-1:0] addr;
        logic [`WB_DATA_W-1:0] data;
        logic [`WB_BE_W-1:0]   be;
        logic                  io;
        logic                  write;
    } bus_cyc_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR,
        ST_RD,
        ST_IO_WR,
        ST_LK_RD,
        ST_LK_WAIT,
        ST_LK_WR
    } bus_state_type;

endpackage

/* File: verif/bus_model.sv */
module bus_model
    import wbuf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  dly,
    input  wire logic        bus_start,
    input  wire bus_cyc_type bus_cyc,
    output logic             bus_idle,
    output logic             bus_done
);
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Cycle log and busy timer
    // =========================================================
    bus_cyc_type log_q[$];
    logic [7:0]  cnt;

    initial begin
        bus_idle = 1'b1;
        bus_done = 1'b0;
        cnt = 8'h00;
    end

    // one cycle at a time
    // A start while busy is still logged, so the bench sees an overlap.
    always @(posedge clk) begin
        bus_done <= 1'b0;
        if (srst) begin
            bus_idle <= 1'b1;
            cnt <= 8'h00;
        end else if (bus_start) begin
            log_q.push_back(bus_cyc);
            bus_idle <= 1'b0;
            cnt <= dly;
        end else if (!bus_idle) begin
            if (cnt == 8'h00) begin
                bus_done <= 1'b1;
                bus_idle <= 1'b1;
            end else begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

/* File: verif/tb_cpu_write_buffer_unit.sv */
module tb_cpu_write_buffer_unit
    import wbuf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Signals and instances
    // =========================================================
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        wr_valid = 1'b0;
    wr_req_type  wr_req = '0;
    logic        wr_io_single = 1'b0;
    logic        rd_valid = 1'b0;
    rd_req_type  rd_req = '0;
    logic        lk_start = 1'b0;
    logic        lk_wr_valid = 1'b0;
    wr_req_type  lk_wr_req = '0;
    logic        invalidate = 1'b0;
    logic [7:0]  dly = 8'h02;
    logic        wr_ready, rd_ready, exec_stall, cache_wr;
    logic [31:0] cache_addr, last_cache;
    logic        bus_start, bus_lock, bus_idle, bus_done;
    bus_cyc_type bus_cyc;
    int          err_total = 0;
    int          n_checks = 0;
    int          n_wait = 0;
    int          base = 0;

    always #25 clk = ~clk;

    cpu_write_buffer_unit i_dut (.clk(clk), .srst(srst),
        .wr_valid(wr_valid), .wr_req(wr_req), .wr_io_single(wr_io_single),
        .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_req(rd_req),
        .rd_ready(rd_ready), .lk_start(lk_start), .lk_wr_valid(lk_wr_valid),
        .lk_wr_req(lk_wr_req), .invalidate(invalidate),
        .exec_stall(exec_stall), .cache_wr(cache_wr),
        .cache_addr(cache_addr), .bus_start(bus_start), .bus_cyc(bus_cyc),
        .bus_lock(bus_lock), .bus_idle(bus_idle), .bus_done(bus_done));

    bus_model i_bus (.clk(clk), .srst(srst), .dly(dly),
        .bus_start(bus_start), .bus_cyc(bus_cyc), .bus_idle(bus_idle),
        .bus_done(bus_done));

    always @(posedge clk) begin
        if (cache_wr === 1'b1) begin
            last_cache <= cache_addr;
        end
    end

    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic close_out();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic start(input logic [7:0] d);
        @(negedge clk);
        dly = d;
        base = i_bus.log_q.size();
    endtask

    task automatic wr(input logic [31:0] a, input logic h, input logic io,
                      input logic sgl);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_req = '{addr: a, data: ~a, be: a[5:2], io: io, hit: h};
        wr_io_single = sgl;
        for (int i = 0; i < 400 && wr_ready !== 1'b1; i++) begin
            @(negedge clk);
            n_wait++;
        end
        @(posedge clk);
    endtask

    task automatic drop();
        @(negedge clk);
        wr_valid = 1'b0;
        wr_io_single = 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic io, input logic lk);
        @(negedge clk);
        rd_valid = !lk;
        lk_start = lk;
        rd_req = '{addr: a, io: io, hit: lk, locked: lk};
        for (int i = 0; i < 400 && rd_ready !== 1'b1; i++) begin
            @(negedge clk);
        end
        chk({31'h0, rd_ready}, 32'h1);
        rd_valid = 1'b0;
        lk_start = 1'b0;
    endtask

    task automatic drain(input int n);
        for (int i = 0; i < 900 && (i_bus.log_q.size() - base < n
             || bus_idle !== 1'b1); i++) begin
            @(negedge clk);
        end
        chk(i_bus.log_q.size() - base, n);
    endtask

    task automatic lg(input int k, input logic [31:0] a, input logic w);
        if (base + k < i_bus.log_q.size()) begin
            chk(i_bus.log_q[base + k].addr, a);
            chk({31'h0, i_bus.log_q[base + k].write}, {31'h0, w});
            if (w) begin
                chk(i_bus.log_q[base + k].data, ~a);
            end
        end else begin
            chk(~a, a);
        end
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic s_bypass();
        int i;
        start(8'h02);
        wr(32'h0000_0100, 1'b1, 1'b0, 1'b0);
        drop();
        for (i = 0; i < 10 && bus_start !== 1'b1; i++) @(negedge clk);
        chk({31'h0, i < 3}, 32'h1);
        drain(1);
        lg(0, 32'h0000_0100, 1'b1);
        chk({28'h0, i_bus.log_q[base].be}, 32'h0);
        chk(last_cache, 32'h0000_0100);
    endtask

    task automatic s_order();
        int w0;
        start(8'h14);
        w0 = n_wait;
        for (int k = 0; k < 24; k++) begin
            wr(32'h0000_0200 + 32'(4 * k), 1'b0, 1'b0, 1'b0);
            if (k == 7) chk(n_wait - w0, 0);
        end
        drop();
        chk({31'h0, n_wait > w0}, 32'h1);
        drain(24);
        for (int k = 0; k < 24; k++) lg(k, 32'h200 + 32'(4 * k), 1'b1);
        chk(last_cache, 32'h0000_0100);
    endtask

    task automatic s_io();
        start(8'h0a);
        wr(32'h0000_0300, 1'b0, 1'b1, 1'b1);
        drop();
        repeat (3) @(negedge clk);
        chk({31'h0, exec_stall}, 32'h1);
        rd(32'h0000_0400, 1'b0, 1'b0);
        drain(2);
        lg(0, 32'h0000_0300, 1'b1);
        chk({31'h0, i_bus.log_q[base].io}, 32'h1);
        lg(1, 32'h0000_0400, 1'b0);
        chk({31'h0, exec_stall}, 32'h0);
    endtask

    task automatic s_rep();
        int w0;
        start(8'h0a);
        w0 = n_wait;
        wr(32'h0000_0310, 1'b0, 1'b1, 1'b0);
        wr(32'h0000_0314, 1'b0, 1'b1, 1'b0);
        wr(32'h0000_0318, 1'b0, 1'b1, 1'b0);
        drop();
        chk(n_wait - w0, 0);
        chk({31'h0, exec_stall}, 32'h0);
        drain(3);
        lg(2, 32'h0000_0318, 1'b1);
    endtask

    task automatic s_reorder();
        start(8'h0a);
        for (int k = 0; k < 3; k++) wr(32'h600 + 32'(4 * k), 1'b1, 1'b0, 1'b0);
        drop();
        repeat (4) @(negedge clk);
        rd(32'h0000_0700, 1'b0, 1'b0);
        rd(32'h0000_0704, 1'b0, 1'b0);
        drain(5);
        lg(1, 32'h0000_0700, 1'b0);
        lg(2, 32'h0000_0604, 1'b1);
        lg(3, 32'h0000_0608, 1'b1);
        lg(4, 32'h0000_0704, 1'b0);
    endtask

    task automatic s_noreord(input logic io, input logic inv);
        start(8'h0a);
        wr(32'h0000_0a00, 1'b1, 1'b0, 1'b0);
        wr(32'h0000_0a04, 1'b1, 1'b0, 1'b0);
        drop();
        repeat (3) @(negedge clk);
        invalidate = inv;
        @(negedge clk);
        invalidate = 1'b0;
        rd(32'h0000_0b00, io, 1'b0);
        drain(3);
        lg(1, 32'h0000_0a04, 1'b1);
        lg(2, 32'h0000_0b00, 1'b0);
    endtask

    task automatic s_lock();
        start(8'h08);
        wr(32'h0000_0800, 1'b1, 1'b0, 1'b0);
        wr(32'h0000_0804, 1'b1, 1'b0, 1'b0);
        drop();
        rd(32'h0000_0900, 1'b0, 1'b1);
        chk({31'h0, bus_lock}, 32'h1);
        chk(i_bus.log_q.size() - base, 3);
        lk_wr_valid = 1'b1;
        lk_wr_req = '{addr: 32'h900, data: ~32'h900, be: 4'h0, io: 1'b0,
                      hit: 1'b1};
        for (int i = 0; i < 400 && bus_start !== 1'b1; i++) @(negedge clk);
        lk_wr_valid = 1'b0;
        for (int i = 0; i < 400 && bus_lock === 1'b1; i++) @(negedge clk);
        drain(4);
        lg(2, 32'h0000_0900, 1'b0);
        lg(3, 32'h0000_0900, 1'b1);
        chk({31'h0, bus_lock}, 32'h0);
        chk(last_cache, 32'h0000_0900);
    endtask

    // =========================================================
    // Main sequence and watchdog
    // =========================================================
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        s_bypass();
        s_order();
        s_io();
        s_rep();
        s_reorder();
        s_noreord(1'b1, 1'b0);
        s_noreord(1'b0, 1'b1);
        s_lock();
        close_out();
    end

    // The whole run needs some 950 cycles; the margin covers slow drains.
    initial begin
        #(50 * 20000);
        err_total++;
        close_out();
    end
endmodule
